//--- rxps_defines.vh
// register offsets, field positions, reset values for the rx port page select block
// assumes inclusion by rxps_page_select.v only
`ifndef RXPS_DEFINES_VH
`define RXPS_DEFINES_VH

// ==========================================
// register offsets
`define RXPS_ADDR_PORT_CAP 8'h4a
`define RXPS_ADDR_EMBED_CFG 8'h4b
`define RXPS_ADDR_PAGE_SEL 8'h4c
`define RXPS_ADDR_STS1 8'h4d
`define RXPS_ADDR_PAGED_LO 8'h4d
`define RXPS_ADDR_PAGED_HI 8'h7f
`define RXPS_ADDR_PAGED2_LO 8'hd0
`define RXPS_ADDR_PAGED2_HI 8'hdf

// ==========================================
// page select field positions
`define RXPS_BIT_WR0 0
`define RXPS_BIT_WR1 1
`define RXPS_BIT_RD_PORT 4
`define RXPS_BIT_PHYS 6

// ==========================================
// embedded type field positions and reset values
`define RXPS_EMB_CNT_HI 7
`define RXPS_EMB_CNT_LO 6
`define RXPS_EMB_CODE_HI 5
`define RXPS_EMB_CODE_LO 0
`define RXPS_EMB_CFG_RST 8'h12
`define RXPS_PORT_CAP_RST 8'h00
`define RXPS_PAGED_RST 8'h00

// ==========================================
// access source codes
`define RXPS_SRC_LOCAL 2'h0
`define RXPS_SRC_LINK0 2'h1
`define RXPS_SRC_LINK1 2'h2

`endif

//--- rxps_page_select.v
// rx port paged register bank with per-source page select and raw embedded type tagging
// assumes one access per cycle from an arbitrated local or control-channel source,
// and a per-port long packet stream with a frame start pulse
//
// Overview of operation
// - 0x4a, 0x4b, 0x4d-0x7f, 0xd0-0xdf are per-port; 0x4c is per-source; other addresses are shared.
// - paged reads come from port 0 or port 1 per read-port bit 4.
// - paged writes go to every port whose write-enable bit is set.
// - local and each control-channel source hold their own page select copy.
// - physical port bit 6 reads 0 locally, carrying port over control channel.
// - read port resets to 0 locally, to carrying port per control channel source.
// - write enables reset 0 locally, only carrying port's enable set per channel source.
// - a port block with write enable clear ignores paged writes.
// - embedded count 00 keeps the raw video type on every long packet.
// - counts 1..3 tag that many first long packets per frame with embedded code.
// - substitution applies only in raw input mode, never for csi-2 input.
// - six-bit embedded code in bits 5:0 resets to 0x12 and replaces raw code.
// - a read-only status bit shows the currently selected read port.
`timescale 1ns/1ns
`default_nettype none
`include "rxps_defines.vh"

module rxps_page_select (
    // clock and reset
    input wire i_clk,
    input wire i_srst,
    // register access
    input wire i_acc_en,
    input wire i_acc_wr,
    input wire [1:0] i_acc_src,
    input wire [7:0] i_acc_addr,
    input wire [7:0] i_acc_wdata,
    output reg [7:0] o_acc_rdata,
    output wire o_acc_paged,
    // shared register file, outside this block
    input wire [7:0] i_shared_rdata,
    output wire o_shared_wr,
    // per-port configuration and status
    input wire [1:0] i_raw_mode,
    input wire [11:0] i_ten_bit_raw_type_code,
    input wire [11:0] i_twelve_bit_raw_type_code,
    input wire [1:0] i_twelve_bit_sel,
    input wire [15:0] i_port_sts1,
    // per-port long packet stream
    input wire [1:0] i_frame_start,
    input wire [1:0] i_long_pkt,
    output wire [11:0] o_pkt_dtype,
    output wire [1:0] o_pkt_embedded
);

    // ==========================================
    // address classification
    wire paged_cfg;
    wire in_range1;
    wire in_range2;
    wire is_sel;
    assign in_range1 = (i_acc_addr >= `RXPS_ADDR_PAGED_LO) && (i_acc_addr <= `RXPS_ADDR_PAGED_HI);
    assign in_range2 = (i_acc_addr >= `RXPS_ADDR_PAGED2_LO) && (i_acc_addr <= `RXPS_ADDR_PAGED2_HI);
    assign paged_cfg = (i_acc_addr == `RXPS_ADDR_PORT_CAP) || (i_acc_addr == `RXPS_ADDR_EMBED_CFG);
    assign is_sel = (i_acc_addr == `RXPS_ADDR_PAGE_SEL);
    assign o_acc_paged = paged_cfg || in_range1 || in_range2;
    // shared path sees the address untouched by paging state
    assign o_shared_wr = i_acc_en && i_acc_wr && !o_acc_paged && !is_sel;

    // ==========================================
    // per-source page select state, index = source code
    reg [2:0] rd_port_r;
    reg [2:0] wr0_r;
    reg [2:0] wr1_r;
    wire src_link;
    wire src_port;
    wire [1:0] src_idx;
    assign src_link = (i_acc_src == `RXPS_SRC_LINK0) || (i_acc_src == `RXPS_SRC_LINK1);
    assign src_port = (i_acc_src == `RXPS_SRC_LINK1);
    assign src_idx = src_link ? i_acc_src : `RXPS_SRC_LOCAL;

    always @(posedge i_clk) begin
        if (i_srst) begin
            // local: read 0, no writes; link n: read n, write n only
            rd_port_r <= 3'b100;
            wr0_r <= 3'b010;
            wr1_r <= 3'b100;
        end else if (i_acc_en && i_acc_wr && is_sel) begin
            // only the accessing source's copy moves
            rd_port_r[src_idx] <= i_acc_wdata[`RXPS_BIT_RD_PORT];
            wr0_r[src_idx] <= i_acc_wdata[`RXPS_BIT_WR0];
            wr1_r[src_idx] <= i_acc_wdata[`RXPS_BIT_WR1];
        end
    end

    wire cur_rd;
    wire [1:0] cur_wr;
    assign cur_rd = rd_port_r[src_idx];
    assign cur_wr = {wr1_r[src_idx], wr0_r[src_idx]};

    // ==========================================
    // per-port paged storage: cap, embed cfg, ranges 0x4e-0x7f and 0xd0-0xdf
    // 0x4d is the status byte and is read-only
    wire [6:0] mem_idx;
    wire mem_hit;
    wire acc_write;
    wire [7:0] cap_p0;
    wire [7:0] cap_p1;
    wire [7:0] emb_p0;
    wire [7:0] emb_p1;
    wire [7:0] mem_p0;
    wire [7:0] mem_p1;
    assign acc_write = i_acc_en && i_acc_wr;
    assign mem_hit = (in_range1 && (i_acc_addr != `RXPS_ADDR_STS1)) || in_range2;
    // range1 maps 0x4e-0x7f to 0..49, range2 0xd0-0xdf to 50..65
    // seven bits kept: six would fold 0xde/0xdf onto 0x4e/0x4f
    assign mem_idx = in_range1 ? (i_acc_addr[6:0] - 7'h4e) : (i_acc_addr[6:0] - 7'h1e);

    // disabled ports keep their contents
    rxps_port_bank u_bank0 (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_wr_en(acc_write && cur_wr[0]),
        .i_addr(i_acc_addr),
        .i_mem_hit(mem_hit),
        .i_mem_idx(mem_idx),
        .i_wdata(i_acc_wdata),
        .o_cap(cap_p0),
        .o_emb(emb_p0),
        .o_mem_rdata(mem_p0)
    );

    rxps_port_bank u_bank1 (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_wr_en(acc_write && cur_wr[1]),
        .i_addr(i_acc_addr),
        .i_mem_hit(mem_hit),
        .i_mem_idx(mem_idx),
        .i_wdata(i_acc_wdata),
        .o_cap(cap_p1),
        .o_emb(emb_p1),
        .o_mem_rdata(mem_p1)
    );

    // ==========================================
    // read mux, combinational so data returns in the access cycle
    reg [7:0] sts1_v;
    always @* begin
        sts1_v = cur_rd ? i_port_sts1[15:8] : i_port_sts1[7:0];
        sts1_v[7] = 1'b0;
        sts1_v[`RXPS_BIT_PHYS] = cur_rd;
        o_acc_rdata = 8'h00;
        if (is_sel) begin
            o_acc_rdata[`RXPS_BIT_PHYS] = src_port;
            o_acc_rdata[`RXPS_BIT_RD_PORT] = cur_rd;
            o_acc_rdata[`RXPS_BIT_WR1] = cur_wr[1];
            o_acc_rdata[`RXPS_BIT_WR0] = cur_wr[0];
        end else if (i_acc_addr == `RXPS_ADDR_PORT_CAP) begin
            o_acc_rdata = cur_rd ? cap_p1 : cap_p0;
        end else if (i_acc_addr == `RXPS_ADDR_EMBED_CFG) begin
            o_acc_rdata = cur_rd ? emb_p1 : emb_p0;
        end else if (i_acc_addr == `RXPS_ADDR_STS1) begin
            o_acc_rdata = sts1_v;
        end else if (mem_hit) begin
            o_acc_rdata = cur_rd ? mem_p1 : mem_p0;
        end else begin
            o_acc_rdata = i_shared_rdata;
        end
    end

    // ==========================================
    // embedded type tagging, one lane per port
    wire [5:0] raw_code_p0;
    wire [5:0] raw_code_p1;
    assign raw_code_p0 = i_twelve_bit_sel[0] ? i_twelve_bit_raw_type_code[5:0] : i_ten_bit_raw_type_code[5:0];
    assign raw_code_p1 = i_twelve_bit_sel[1] ? i_twelve_bit_raw_type_code[11:6] : i_ten_bit_raw_type_code[11:6];

    rxps_tag_lane u_lane0 (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_raw_mode(i_raw_mode[0]),
        .i_emb_cfg(emb_p0),
        .i_raw_code(raw_code_p0),
        .i_frame_start(i_frame_start[0]),
        .i_long_pkt(i_long_pkt[0]),
        .o_dtype(o_pkt_dtype[5:0]),
        .o_embedded(o_pkt_embedded[0])
    );

    rxps_tag_lane u_lane1 (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_raw_mode(i_raw_mode[1]),
        .i_emb_cfg(emb_p1),
        .i_raw_code(raw_code_p1),
        .i_frame_start(i_frame_start[1]),
        .i_long_pkt(i_long_pkt[1]),
        .o_dtype(o_pkt_dtype[11:6]),
        .o_embedded(o_pkt_embedded[1])
    );

endmodule // rxps_page_select

// ==========================================
// one receive port's paged registers and page memory
module rxps_port_bank (
    // clock and reset
    input wire i_clk,
    input wire i_srst,
    // write side, already qualified by this port's enable
    input wire i_wr_en,
    input wire [7:0] i_addr,
    input wire i_mem_hit,
    input wire [6:0] i_mem_idx,
    input wire [7:0] i_wdata,
    // stored values
    output reg [7:0] o_cap,
    output reg [7:0] o_emb,
    output wire [7:0] o_mem_rdata
);

    reg [7:0] page_mem [0:65];

    always @(posedge i_clk) begin
        if (i_srst) begin
            o_cap <= `RXPS_PORT_CAP_RST;
            o_emb <= `RXPS_EMB_CFG_RST;
        end else if (i_wr_en) begin
            if (i_addr == `RXPS_ADDR_PORT_CAP) begin
                o_cap <= i_wdata;
            end
            if (i_addr == `RXPS_ADDR_EMBED_CFG) begin
                o_emb <= i_wdata;
            end
        end
    end

    // memory has no reset: cheaper storage, reads unknown until written
    always @(posedge i_clk) begin
        if (!i_srst && i_wr_en && i_mem_hit) begin
            page_mem[i_mem_idx] <= i_wdata;
        end
    end

    // index beyond 65 only occurs off the memory ranges, where the mux ignores it
    assign o_mem_rdata = page_mem[i_mem_idx];

endmodule // rxps_port_bank

// ==========================================
// one port's long packet counter and data type select
module rxps_tag_lane (
    // clock and reset
    input wire i_clk,
    input wire i_srst,
    // lane configuration
    input wire i_raw_mode,
    input wire [7:0] i_emb_cfg,
    input wire [5:0] i_raw_code,
    // packet stream
    input wire i_frame_start,
    input wire i_long_pkt,
    output reg [5:0] o_dtype,
    output reg o_embedded
);

    reg [1:0] pkt_cnt_r;
    reg [1:0] pkt_cnt_nxt;
    wire [1:0] line_count;
    wire tag_now;

    assign line_count = i_emb_cfg[`RXPS_EMB_CNT_HI:`RXPS_EMB_CNT_LO];
    // csi input never tagged
    assign tag_now = i_raw_mode && (pkt_cnt_r < line_count);

    // saturate at 3: counts above the largest setting never matter
    always @* begin
        pkt_cnt_nxt = pkt_cnt_r;
        if (i_frame_start) begin
            pkt_cnt_nxt = 2'h0;
        end else if (i_long_pkt && (pkt_cnt_r != 2'h3)) begin
            pkt_cnt_nxt = pkt_cnt_r + 2'h1;
        end
    end

    always @(posedge i_clk) begin
        if (i_srst) begin
            pkt_cnt_r <= 2'h0;
            o_dtype <= 6'h00;
            o_embedded <= 1'b0;
        end else begin
            pkt_cnt_r <= pkt_cnt_nxt;
            if (tag_now) begin
                o_dtype <= i_emb_cfg[`RXPS_EMB_CODE_HI:`RXPS_EMB_CODE_LO];
                o_embedded <= 1'b1;
            end else begin
                o_dtype <= i_raw_code;
                o_embedded <= 1'b0;
            end
        end
    end

endmodule // rxps_tag_lane
`default_nettype wire

//--- rxps_page_select_chk.sv
// port checker for the rx port page select block
// assumes one clock, sync active-high reset, bound after the module
`timescale 1ns/1ns
`default_nettype none
module rxps_chk (
    // watched ports
    input wire logic i_clk, i_srst, i_acc_en, i_acc_wr, o_acc_paged, o_shared_wr,
    input wire logic [1:0] i_acc_src, i_long_pkt, i_raw_mode, i_twelve_bit_sel, o_pkt_embedded,
    input wire logic [7:0] i_acc_addr, o_acc_rdata, i_shared_rdata,
    input wire logic [11:0] i_ten_bit_raw_type_code, i_twelve_bit_raw_type_code, o_pkt_dtype,
    input wire logic [15:0] i_port_sts1
);
    // ==========================================
    // properties
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    a_paged_decode: assert property (
        o_acc_paged == (i_acc_addr inside {8'h4a, 8'h4b, [8'h4d:8'h7f], [8'hd0:8'hdf]})) else $error("paged decode");
    a_shared_strobe: assert property (
        o_shared_wr == (i_acc_en && i_acc_wr && !o_acc_paged && i_acc_addr != 8'h4c)) else $error("shared strobe");
    a_shared_read: assert property (
        !o_acc_paged && i_acc_addr != 8'h4c |-> o_acc_rdata == i_shared_rdata) else $error("shared read");
    a_phys_port: assert property (
        i_acc_addr == 8'h4c |-> {o_acc_rdata[7:5], o_acc_rdata[3:2]} == {1'b0, i_acc_src == 2'h2, 3'h0})
        else $error("phys port bit");
    // first edge after reset still shows each source's reset copy
    a_reset_sel: assert property (
        $past(i_srst) && i_acc_addr == 8'h4c |-> o_acc_rdata[4:0] ==
        (i_acc_src == 2'h1 ? 5'h01 : (i_acc_src == 2'h2 ? 5'h12 : 5'h00))) else $error("reset select");
    a_status_page: assert property (
        i_acc_addr == 8'h4d |-> o_acc_rdata == {1'b0, o_acc_rdata[6],
        o_acc_rdata[6] ? i_port_sts1[13:8] : i_port_sts1[5:0]}) else $error("status page");
    a_csi_plain: assert property (
        i_long_pkt[1] && !i_raw_mode[1] |=> !o_pkt_embedded[1]) else $error("csi embedded");
    a_raw_type: assert property (
        i_long_pkt[0] ##1 !o_pkt_embedded[0] |-> o_pkt_dtype[5:0] == ($past(i_twelve_bit_sel[0]) ?
        $past(i_twelve_bit_raw_type_code[5:0]) : $past(i_ten_bit_raw_type_code[5:0]))) else $error("raw type");
    c_paged_wr: cover property (i_acc_en && i_acc_wr && i_acc_addr == 8'h50);
    c_embedded: cover property (o_pkt_embedded[0]);
    c_link_rd: cover property (i_acc_src == 2'h2 && i_acc_addr == 8'h4b);
endmodule // rxps_chk
bind rxps_page_select rxps_chk u_rxps_chk (.i_clk, .i_srst, .i_acc_en, .i_acc_wr, .o_acc_paged,
    .o_shared_wr, .i_acc_src, .i_long_pkt, .i_raw_mode, .i_twelve_bit_sel, .o_pkt_embedded, .i_acc_addr,
    .o_acc_rdata, .i_shared_rdata, .i_ten_bit_raw_type_code, .i_twelve_bit_raw_type_code, .o_pkt_dtype,
    .i_port_sts1);
`default_nettype wire

//--- rxps_host.sv
// model of the access host, local or over a control channel
// assumes calls from the bench, one access per cycle
`timescale 1ns/1ns
`default_nettype none
module rxps_host (
    // clock and read data
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    // access request
    output var logic o_en = 1'b0,
    output var logic o_wr = 1'b0,
    output var logic [1:0] o_src = 2'h2,
    output var logic [7:0] o_addr = 8'h4c,
    output var logic [7:0] o_wdata = 8'h00
);
    // ==========================================
    // access tasks
    // strobe stays up into the next call so writes can go back to back
    task automatic wr(input logic [1:0] s, input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        {o_en, o_wr, o_src, o_addr, o_wdata} = {2'h3, s, a, d};
    endtask
    // reads need no edge, data sampled once settled
    task automatic rd(input logic [1:0] s, input logic [7:0] a, output logic [7:0] q);
        @(negedge i_clk);
        {o_en, o_wr, o_src, o_addr} = {2'h2, s, a};
        #2 q = i_rdata;
    endtask
endmodule // rxps_host
`default_nettype wire

//--- rxps_tb.sv
// self-checking bench for the rx port page select block
// assumes rxps_host drives accesses and the checker is bound onto the design
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic i_clk, i_srst, en, wr;
    logic [1:0] src, raw, fs, lp, emb;
    logic [7:0] addr, wdata, rdata, q;
    logic [11:0] dtype;
    int err_count = 0;
    int compares = 0;
    rxps_host u_rxps_host (.i_clk(i_clk), .i_rdata(rdata), .o_en(en), .o_wr(wr), .o_src(src),
        .o_addr(addr), .o_wdata(wdata));
    rxps_page_select u_rxps_page_select (.i_clk(i_clk), .i_srst(i_srst), .i_acc_en(en), .i_acc_wr(wr),
        .i_acc_src(src), .i_acc_addr(addr), .i_acc_wdata(wdata), .o_acc_rdata(rdata), .o_acc_paged(),
        .i_shared_rdata(8'h77), .o_shared_wr(), .i_raw_mode(raw), .i_ten_bit_raw_type_code(12'h0ab),
        .i_twelve_bit_raw_type_code(12'hb2c), .i_twelve_bit_sel(2'h2), .i_port_sts1(16'h3f15),
        .i_frame_start(fs), .i_long_pkt(lp), .o_pkt_dtype(dtype), .o_pkt_embedded(emb));
    // ==========================================
    // checks and run control
    task automatic chk(input string n, input logic [11:0] g, input logic [11:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rc(input logic [1:0] s, input logic [7:0] a, input logic [7:0] e);
        u_rxps_host.rd(s, a, q);
        chk("rdata", {4'h0, q}, {4'h0, e});
    endtask
    task automatic stop_test;
        if (err_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        #20000;
        err_count++;
        stop_test();
    end
    initial begin
        {i_srst, raw, fs, lp} = 7'h50;
        repeat (2) @(negedge i_clk);
        i_srst = 1'b0;
        rc(2'h2, 8'h4c, 8'h52);
        rc(2'h1, 8'h4c, 8'h01);
        rc(2'h0, 8'h4c, 8'h00);
        rc(2'h0, 8'h4b, 8'h12);
        rc(2'h0, 8'h4a, 8'h00);
        u_rxps_host.wr(2'h1, 8'h4b, 8'h41);
        u_rxps_host.wr(2'h2, 8'h4b, 8'h83);
        rc(2'h0, 8'h4b, 8'h41);
        rc(2'h2, 8'h4b, 8'h83);
        rc(2'h1, 8'h4c, 8'h01);
        u_rxps_host.wr(2'h0, 8'h4c, 8'hff);
        rc(2'h0, 8'h4c, 8'h13);
        u_rxps_host.wr(2'h0, 8'h50, 8'h5a);
        u_rxps_host.wr(2'h0, 8'h4c, 8'h01);
        u_rxps_host.wr(2'h0, 8'h50, 8'ha5);
        rc(2'h0, 8'h50, 8'ha5);
        rc(2'h0, 8'h4d, 8'h15);
        u_rxps_host.wr(2'h0, 8'h4c, 8'h10);
        u_rxps_host.wr(2'h0, 8'h50, 8'h33);
        rc(2'h0, 8'h50, 8'h5a);
        rc(2'h0, 8'h4d, 8'h7f);
        rc(2'h0, 8'h20, 8'h77);
        u_rxps_host.wr(2'h0, 8'h4c, 8'h03);
        u_rxps_host.wr(2'h0, 8'h4f, 8'h11);
        u_rxps_host.wr(2'h0, 8'hdf, 8'h66);
        rc(2'h0, 8'h4f, 8'h11);
        rc(2'h0, 8'hdf, 8'h66);
        // port 0 raw, port 1 csi; four back-to-back packets per frame
        for (int n = 0; n < 4; n++) begin
            u_rxps_host.wr(2'h0, 8'h4b, {n[1:0], 6'h2a});
            rc(2'h2, 8'h4b, {n[1:0], 6'h2a});
            @(negedge i_clk);
            fs = 2'h3;
            @(negedge i_clk);
            {fs, lp} = 4'h3;
            for (int k = 0; k < 4; k++) begin
                @(negedge i_clk);
                lp = (k < 3) ? 2'h3 : 2'h0;
                chk("embedded", {10'h0, emb}, {11'h0, k < n});
                chk("dtype", {6'h0, dtype[5:0]}, {6'h0, (k < n) ? 6'h2a : 6'h2b});
                chk("dtype1", {6'h0, dtype[11:6]}, 12'h02c);
            end
        end
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
